// ==== asrc_out_pkg.sv ====
// constants shared by the sample rate converter output port and its helpers
// assumes one core clock CLK at CLK_HZ and an output bit clock from the receiver
package asrc_out_pkg;

   // core clock and conversion figures
   localparam int CLK_HZ           = 250_000_000;
   localparam int MCLK_NOM_HZ      = 16_000_000;
   localparam int FS_NOM_HZ        = 48_000;
   localparam int WORD_BITS        = 24;
   localparam int UPSAMPLE_RATIO   = 65_536;
   localparam int FRAC_BITS        = $clog2(UPSAMPLE_RATIO);
   localparam longint UPSAMPLE_HZ  = 64'd3_276_800_000;
   localparam int FINE_GRID_PS     = 300;
   localparam int LPF_BAND_HZ      = 20_000;

   // input buffer latency choices, in microseconds and in nominal samples
   localparam int SHORT_DELAY_US   = 700;
   localparam int LONG_DELAY_US    = 3000;
   localparam int PTR_BITS         = 8;
   localparam logic [PTR_BITS-1:0] SHORT_DELAY_SMP =
      PTR_BITS'(SHORT_DELAY_US * FS_NOM_HZ / 1_000_000);
   localparam logic [PTR_BITS-1:0] LONG_DELAY_SMP  =
      PTR_BITS'(LONG_DELAY_US * FS_NOM_HZ / 1_000_000);

   // ratio tracking settling, slow loop is four times longer than fast
   localparam int SLOW_SETTLE_MS   = 800;
   localparam int FAST_SETTLE_MS   = 200;
   localparam logic [3:0] FAST_SHIFT = 4'h4;
   localparam logic [3:0] SLOW_SHIFT =
      FAST_SHIFT + 4'($clog2(SLOW_SETTLE_MS / FAST_SETTLE_MS));

   // input period estimate in core cycles
   localparam int PERIOD_BITS      = 16;
   localparam logic [PERIOD_BITS-1:0] PERIOD_INIT = PERIOD_BITS'(CLK_HZ / FS_NOM_HZ);

   // mute hold after a pointer crossing, in output frames
   localparam logic [7:0] MUTE_HOLD_FRAMES = 8'h80;

   // output frame buffer shape
   localparam int FRAME_FIFO_DEPTH = 4;

   // converter sequencing
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV  = 2'b01,
      ST_PUSH = 2'b10
   } core_state_e;

endpackage

// ==== level_sync2.sv ====
// two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; bits are not coherent with one another
`timescale 1ns/10ps
module level_sync2 #(
   parameter int W = 1
) (
   // clock of the receiving domain
   input  wire logic         clk,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end

endmodule

// ==== frame_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two and one clock for both sides
`timescale 1ns/10ps
module frame_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // full when pointers differ only in the wrap bit
   assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule

// ==== asrc_output_port.sv ====
// Summary of operation
// - polarity low: data changes on falling bit clock; high: changes on rising.
// - trigger select high: any channel clock edge starts a word; low: word clock rise.
// - first-bit delay high: first bit one bit clock after start event.
// - latency select high picks about 700 us buffering, low about 3 ms.
// - latency and settling selects may change anytime, asynchronously, safely.
// - conversion core runs on its own free clock unrelated to serial clocks.
// - active-low chip reset holds the block reset while low.
// - mute indicator high while buffer pointers overlap and through the 128-frame hold after, low otherwise.
// - mute request forces every serial word that starts after it is sampled to zero; a word in progress finishes.
// - settling select high gives slow 800 ms tracking, low fast 200 ms.
// - conversion behaves like upsampling by 65536 with zero stuffing.
// - interpolation filter limits bandwidth to 20 kHz; the code interpolates linearly between two samples, with no 20 kHz band limit.
// - each output sample is the newest fine-grid value before its instant.
// - fine time grid of about 300 ps, 3.2768 GHz equivalent rate.
// - a pointer crossing holds the mute indicator high for 128 output frames.
// - two channels per frame, 24-bit two's complement words, msb first.
//
// output port of a stereo sample rate converter: input buffer, ratio tracking,
// fractional interpolation, a frame fifo and the serial shifter on the bit clock
// assumes input samples arrive on the core clock and the receiver owns all serial clocks
`timescale 1ns/10ps
module asrc_output_port
   import asrc_out_pkg::*;
#(
   parameter int BUF_DEPTH = 256
) (
   // core clock and resets
   input  wire logic                 CLK,
   input  wire logic                 SRST,
   input  wire logic                 CHIP_RESET_N,
   // input samples from the input port, core clock domain
   input  wire logic                 IN_VALID,
   input  wire logic [WORD_BITS-1:0] IN_LEFT,
   input  wire logic [WORD_BITS-1:0] IN_RIGHT,
   output logic                      IN_READY,
   // serial output link, clocked by the receiver
   input  wire logic                 OUT_BIT_CLK,
   input  wire logic                 OUT_WORD_CLK,
   input  wire logic                 OUT_CHANNEL_CLOCK,
   output logic                      OUT_DATA,
   // asynchronous mode pins
   input  wire logic                 OUT_BITCLK_POLARITY,
   input  wire logic                 OUT_FRAME_TRIGGER_SEL,
   input  wire logic                 OUT_FIRST_BIT_DELAY,
   input  wire logic                 SHORT_LATENCY_SEL,
   input  wire logic                 SLOW_SETTLING_SEL,
   // mute
   input  wire logic                 MUTE_REQ,
   output logic                      MUTE_IND
);

   localparam int FW = 2 * WORD_BITS;
   logic [6:0] pins_s;
   wire        rst_n_s   = pins_s[6];
   wire        short_s   = pins_s[5];
   wire        slow_s    = pins_s[4];
   wire        mute_s    = pins_s[3];
   wire [2:0]  link_mode = pins_s[2:0];

   // every asynchronous pin is resynchronised before use
   level_sync2 #(.W(7)) u_pin_sync (
      .clk (CLK),
      .d   ({CHIP_RESET_N, SHORT_LATENCY_SEL, SLOW_SETTLING_SEL, MUTE_REQ,
             OUT_BITCLK_POLARITY, OUT_FRAME_TRIGGER_SEL, OUT_FIRST_BIT_DELAY}),
      .q   (pins_s)
   );
   wire core_rst = SRST || !rst_n_s;
   logic [FW-1:0]          buf_q [BUF_DEPTH];
   logic [PTR_BITS-1:0]    wptr_q;
   logic [PTR_BITS:0]      fill_q;
   logic [PERIOD_BITS-1:0] elapsed_q;
   logic [PERIOD_BITS-1:0] period_q;
   logic [PTR_BITS-1:0]    delay_q;
   logic [3:0]             shift_q;
   logic [7:0]             mute_cnt_q;
   core_state_e            state_q;
   logic [4:0]             div_cnt_q;
   logic [PERIOD_BITS:0]   rem_q;
   logic [FRAC_BITS-1:0]   frac_q;
   logic [FW-1:0]          hold_q;
   logic                   ack_tgl_q;
   logic                   req_s;
   logic                   req_prev_q;
   logic                   mute_core_q;
   logic [2:0]             mode_core_q;
   logic                   fifo_space;
   logic                   fifo_avail;
   logic [FW-1:0]          fifo_dout;
   logic [FW-1:0]          conv_word;

   // latency and settling choices follow the synchronised pins each cycle
   always_ff @(posedge CLK) begin
      if (core_rst) begin
         delay_q <= LONG_DELAY_SMP;
         shift_q <= FAST_SHIFT;
      end else begin
         delay_q <= short_s ? SHORT_DELAY_SMP : LONG_DELAY_SMP;
         shift_q <= slow_s ? SLOW_SHIFT : FAST_SHIFT;
      end
   end

   // input buffer write; the sample pair is stored as one word
   always_ff @(posedge CLK) begin
      if (IN_VALID) begin
         buf_q[wptr_q] <= {IN_LEFT, IN_RIGHT};
      end
   end

   // ratio tracking: leaky average of the input period, gain set by settling mode
   wire signed [PERIOD_BITS:0] per_err  = $signed({1'b0, elapsed_q}) - $signed({1'b0, period_q});
   wire signed [PERIOD_BITS:0] per_step = per_err >>> shift_q;
   wire [PERIOD_BITS-1:0]      per_next = period_q + per_step[PERIOD_BITS-1:0];

   always_ff @(posedge CLK) begin
      if (core_rst) begin
         wptr_q    <= '0;
         fill_q    <= '0;
         elapsed_q <= '0;
         period_q  <= PERIOD_INIT;
         IN_READY  <= 1'b0;
      end else begin
         IN_READY <= 1'b1;
         if (IN_VALID) begin
            wptr_q    <= wptr_q + 1'b1;
            elapsed_q <= '0;
            period_q  <= (per_next == '0) ? period_q : per_next;
            if (fill_q != (PTR_BITS+1)'(BUF_DEPTH)) begin
               fill_q <= fill_q + 1'b1;
            end
         end else if (elapsed_q != '1) begin
            elapsed_q <= elapsed_q + 1'b1;
         end
      end
   end

   // read side sits a fixed latency behind the writer; pointers are said to cross
   // when too few samples are held or the writer has stalled for two periods
   wire [PTR_BITS-1:0] rd_new   = wptr_q - 8'h01 - delay_q;
   wire [PTR_BITS-1:0] rd_old   = rd_new - 8'h01;
   wire                few_smp  = fill_q < ({1'b0, delay_q} + 9'h002);
   wire                stalled  = {1'b0, elapsed_q} >= {period_q, 1'b0};
   wire                crossing = (state_q == ST_IDLE) && fifo_space && (few_smp || stalled);
   // frame fifo between the converter and the link handshake
   wire           req_edge = req_s != req_prev_q;
   frame_fifo #(.WIDTH(FW), .DEPTH(FRAME_FIFO_DEPTH)) u_frame_fifo (
      .clk       (CLK),
      .srst      (core_rst),
      .in_valid  (state_q == ST_PUSH),
      .in_ready  (fifo_space),
      .in_data   (conv_word),
      .out_valid (fifo_avail),
      .out_ready (req_edge),
      .out_data  (fifo_dout)
   );

   // linear interpolation per channel, old + (new - old) * frac / 65536; cheap, at
   // the cost of weaker image rejection above the audio band than a long kernel
   for (genvar ch = 0; ch < 2; ch++) begin : g_interp
      wire signed [WORD_BITS-1:0] s_old = buf_q[rd_old][ch*WORD_BITS +: WORD_BITS];
      wire signed [WORD_BITS-1:0] s_new = buf_q[rd_new][ch*WORD_BITS +: WORD_BITS];
      wire signed [WORD_BITS:0]   diff  = s_new - s_old;
      wire signed [WORD_BITS+FRAC_BITS+1:0] prod = diff * $signed({1'b0, frac_q});
      wire signed [WORD_BITS:0]   step  = prod[WORD_BITS+FRAC_BITS:FRAC_BITS];
      wire signed [WORD_BITS:0]   sum   = s_old + step;
      assign conv_word[ch*WORD_BITS +: WORD_BITS] = sum[WORD_BITS-1:0];
   end
   // converter sequence: fraction of the input period elapsed, by restoring division
   wire [PERIOD_BITS-1:0] el_clip  = (elapsed_q >= period_q) ? period_q - 1'b1 : elapsed_q;
   wire [PERIOD_BITS+1:0] rem_dbl  = {rem_q, 1'b0};
   wire                   rem_ge   = rem_dbl >= {2'b00, period_q};
   wire [PERIOD_BITS+1:0] rem_sub  = rem_dbl - {2'b00, period_q};

   always_ff @(posedge CLK) begin
      if (core_rst) begin
         state_q   <= ST_IDLE;
         div_cnt_q <= '0;
         rem_q     <= '0;
         frac_q    <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (fifo_space) begin
                  rem_q     <= {1'b0, el_clip};
                  frac_q    <= '0;
                  div_cnt_q <= 5'(FRAC_BITS);
                  state_q   <= ST_DIV;
               end
            end
            ST_DIV: begin
               // one quotient bit a cycle, 16 bits give the 65536-step grid
               rem_q     <= rem_ge ? rem_sub[PERIOD_BITS:0] : rem_dbl[PERIOD_BITS:0];
               frac_q    <= {frac_q[FRAC_BITS-2:0], rem_ge};
               div_cnt_q <= div_cnt_q - 1'b1;
               if (div_cnt_q == 5'h01) begin
                  state_q <= ST_PUSH;
               end
            end
            ST_PUSH: begin
               if (fifo_space) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // mute hold counts output frames; a new crossing wins over the countdown
   always_ff @(posedge CLK) begin
      if (core_rst) begin
         mute_cnt_q <= '0;
         MUTE_IND   <= 1'b0;
      end else begin
         if (crossing) begin
            mute_cnt_q <= MUTE_HOLD_FRAMES;
         end else if (req_edge && mute_cnt_q != '0) begin
            mute_cnt_q <= mute_cnt_q - 1'b1;
         end
         MUTE_IND <= (mute_cnt_q != '0);
      end
   end

   // frame handover: each link request pops one frame into a held word and
   // answers by toggle; an empty fifo answers with midscale rather than stalling
   always_ff @(posedge CLK) begin
      if (core_rst) begin
         hold_q      <= '0;
         ack_tgl_q   <= 1'b0;
         req_prev_q  <= 1'b0;
         mute_core_q <= 1'b0;
         mode_core_q <= '0;
      end else begin
         req_prev_q  <= req_s;
         mute_core_q <= mute_s;
         mode_core_q <= link_mode;
         if (req_edge) begin
            hold_q    <= fifo_avail ? fifo_dout : '0;
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   // link domain on the receiver's bit clock, unrelated to the core clock
   logic       req_tgl_q;
   logic [5:0] lk_s;
   wire        lk_rst   = lk_s[5];
   wire        ack_s    = lk_s[4];
   wire        mute_l   = lk_s[3];
   wire        pol_l    = lk_s[2];
   wire        trig_l   = lk_s[1];
   wire        dly_l    = lk_s[0];
   level_sync2 #(.W(6)) u_link_sync (
      .clk (OUT_BIT_CLK),
      .d   ({core_rst, ack_tgl_q, mute_core_q, mode_core_q}),
      .q   (lk_s)
   );
   level_sync2 #(.W(1)) u_req_sync (
      .clk (CLK),
      .d   (req_tgl_q),
      .q   (req_s)
   );
   logic                 wclk_prev_q;
   logic                 lr_prev_q;
   logic                 ack_prev_q;
   logic [WORD_BITS-1:0] left_q;
   logic [WORD_BITS-1:0] right_q;
   logic [WORD_BITS-1:0] shreg_q;
   logic [4:0]           left_bits_q;
   logic                 data_rise_q;
   logic                 data_fall_q;

   // word start: any channel clock edge, or a word clock rise
   wire start_ev = trig_l ? (OUT_CHANNEL_CLOCK != lr_prev_q)
                          : (OUT_WORD_CLK && !wclk_prev_q);
   // channel clock high carries the left word; mute sampled only here
   wire [WORD_BITS-1:0] word_sel = mute_l ? '0
                                  : (OUT_CHANNEL_CLOCK ? left_q : right_q);

   always_ff @(posedge OUT_BIT_CLK) begin
      if (lk_rst) begin
         wclk_prev_q <= 1'b0;
         lr_prev_q   <= 1'b0;
         ack_prev_q  <= 1'b0;
         req_tgl_q   <= 1'b0;
         left_q      <= '0;
         right_q     <= '0;
      end else begin
         wclk_prev_q <= OUT_WORD_CLK;
         lr_prev_q   <= OUT_CHANNEL_CLOCK;
         ack_prev_q  <= ack_s;
         // the running channel clock paces frame requests
         if (start_ev && OUT_CHANNEL_CLOCK) begin
            req_tgl_q <= ~req_tgl_q;
         end
         if (ack_s != ack_prev_q) begin
            left_q  <= hold_q[FW-1:WORD_BITS];
            right_q <= hold_q[WORD_BITS-1:0];
         end
      end
   end

   // msb-first shifter; bits after the 24th read as zero
   always_ff @(posedge OUT_BIT_CLK) begin
      if (lk_rst) begin
         shreg_q     <= '0;
         left_bits_q <= '0;
         data_rise_q <= 1'b0;
      end else if (start_ev) begin
         if (dly_l) begin
            data_rise_q <= 1'b0;
            shreg_q     <= word_sel;
            left_bits_q <= 5'(WORD_BITS);
         end else begin
            data_rise_q <= word_sel[WORD_BITS-1];
            shreg_q     <= {word_sel[WORD_BITS-2:0], 1'b0};
            left_bits_q <= 5'(WORD_BITS - 1);
         end
      end else if (left_bits_q != '0) begin
         data_rise_q <= shreg_q[WORD_BITS-1];
         shreg_q     <= {shreg_q[WORD_BITS-2:0], 1'b0};
         left_bits_q <= left_bits_q - 1'b1;
      end else begin
         data_rise_q <= 1'b0;
      end
   end

   // half-cycle retime so that data changes on the falling edge
   always_ff @(negedge OUT_BIT_CLK) begin
      data_fall_q <= data_rise_q;
   end

   // the two retimed copies are held stable; the select is a quasi-static pin
   assign OUT_DATA = pol_l ? data_rise_q : data_fall_q;

   // checks; the mute load, latency, settling and division antecedents wait for a sampled reset release, as the chip reset
   // pin leaves reset on a clock edge rather than just after one
   chk_mute_hold_load: assert property (@(posedge CLK) disable iff (core_rst)
      !core_rst && crossing |=> mute_cnt_q == 8'h80)
      else $error("mute hold not loaded with 128 on crossing");
   chk_mute_ind_follow: assert property (@(posedge CLK) disable iff (core_rst)
      (mute_cnt_q != 8'h00) |=> MUTE_IND)
      else $error("mute indicator low while hold count runs");
   chk_latency_select: assert property (@(posedge CLK) disable iff (core_rst)
      !core_rst |=> delay_q == ($past(short_s) ? 8'h21 : 8'h90))
      else $error("buffer latency does not follow select");
   chk_settle_shift: assert property (@(posedge CLK) disable iff (core_rst)
      !core_rst && $rose(slow_s) |=> shift_q == 4'h6)
      else $error("slow settling gain not applied");
   chk_div_length: assert property (@(posedge CLK) disable iff (core_rst)
      !core_rst && state_q == ST_IDLE && fifo_space |=>
      (state_q == ST_DIV && div_cnt_q == 5'h10) ##15
      (state_q == ST_DIV && div_cnt_q == 5'h01) ##1 (state_q == ST_PUSH))
      else $error("fraction division not sixteen steps");
   chk_reset_quiet: assert property (@(posedge CLK)
      !rst_n_s |=> mute_cnt_q == 8'h00 && state_q == ST_IDLE)
      else $error("core not held in reset by chip reset");
   chk_mute_word_zero: assert property (@(posedge OUT_BIT_CLK) disable iff (lk_rst)
      (start_ev && mute_l) |=> !data_rise_q ##1 !data_rise_q)
      else $error("muted word carries a one bit");
   chk_first_bit_time: assert property (@(posedge OUT_BIT_CLK) disable iff (lk_rst)
      (start_ev && dly_l) ##1 !start_ev |=> data_rise_q == $past(shreg_q[WORD_BITS-1]))
      else $error("delayed msb not sent one bit clock late");

endmodule

// ==== serial_rx_model.sv ====
// receiver model: makes the word and channel clocks and captures the serial words
// assumes the bench supplies a free-running bit clock of 64 bit periods a frame
`timescale 1ns/10ps
module serial_rx_model (
   // bit clock and mode pins shared with the device
   input  wire logic        bit_clk,
   input  wire logic        pol,
   input  wire logic        trig,
   input  wire logic        dly,
   input  wire logic        data,
   // frame clocks driven to the device
   output logic             word_clk,
   output logic             chan_clk,
   // last captured words
   output logic [23:0]      left_word,
   output logic [23:0]      right_word
);
   logic [5:0]  pos_q = 6'h00;
   logic [23:0] shift_q = 24'h000000;
   // word clock rises four bits after the channel edge so the two triggers differ
   wire  [5:0]  base = trig ? 6'h00 : 6'h04;

   initial begin
      word_clk = 1'b0;
      chan_clk = 1'b1;
   end

   // store bit k of a word, counted from the start event, msb first
   task automatic grab(input logic [5:0] k);
      if (k[4:0] < 5'h18) begin
         shift_q[5'h17 - k[4:0]] = data;
         if (k[4:0] == 5'h17) begin
            if (k[5]) right_word = shift_q;
            else left_word = shift_q;
         end
      end
   endtask

   // normal polarity: sample on rising, one bit after the start edge
   always @(posedge bit_clk) begin
      if (!pol) grab(pos_q - base - 6'h01 - {5'h00, dly});
   end

   // clocks move on falling edges so the device sees them settled; never stops
   always @(negedge bit_clk) begin
      if (pol) grab(pos_q - base - {5'h00, dly});
      pos_q <= pos_q + 6'h01;
      chan_clk <= (pos_q + 6'h01) < 6'h20;
      word_clk <= ((pos_q + 6'h01) & 6'h1F) == 6'h04;
   end
endmodule

// ==== asrc_output_port_and_mute_control_bench.sv ====
// bench for the converter output port: constant input, receiver model on the link
// assumes one input sample per output frame, so the buffer fill rises by one sample a frame
`timescale 1ns/10ps
module asrc_output_port_and_mute_control_bench import asrc_out_pkg::*;;
   localparam logic [23:0] DC_L = 24'h5A3C81;
   localparam logic [23:0] DC_R = 24'hA1B2C3;
   localparam int FRAME_CYC = 1024; // 64 bit clocks of 64 ns
   logic clk = 1'b0, srst = 1'b1, chip_rst_n = 1'b1, in_valid = 1'b0, in_ready;
   logic bit_clk = 1'b0, word_clk, chan_clk, out_data, mute_req = 1'b0, mute_ind;
   logic pol = 1'b0, trig = 1'b1, dly = 1'b0, short_sel = 1'b1, slow_sel = 1'b0;
   logic [23:0] rx_l, rx_r;
   int mismatches = 0, checked = 0, cycles = 0;

   always #2 clk = ~clk;
   // bit clock offset so its edges never meet the core clock edges
   initial begin
      #0.7;
      forever #32 bit_clk = ~bit_clk;
   end

   asrc_output_port dut (.CLK(clk), .SRST(srst), .CHIP_RESET_N(chip_rst_n),
      .IN_VALID(in_valid), .IN_LEFT(DC_L), .IN_RIGHT(DC_R), .IN_READY(in_ready),
      .OUT_BIT_CLK(bit_clk), .OUT_WORD_CLK(word_clk), .OUT_CHANNEL_CLOCK(chan_clk),
      .OUT_DATA(out_data), .OUT_BITCLK_POLARITY(pol), .OUT_FRAME_TRIGGER_SEL(trig),
      .OUT_FIRST_BIT_DELAY(dly), .SHORT_LATENCY_SEL(short_sel),
      .SLOW_SETTLING_SEL(slow_sel), .MUTE_REQ(mute_req), .MUTE_IND(mute_ind));

   serial_rx_model rx (.bit_clk(bit_clk), .pol(pol), .trig(trig), .dly(dly),
      .data(out_data), .word_clk(word_clk), .chan_clk(chan_clk),
      .left_word(rx_l), .right_word(rx_r));

   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic frames(input int n);
      repeat (n * FRAME_CYC) @(posedge clk);
      #1;
   endtask

   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // input strobe once a frame; cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      in_valid <= #1 (cycles % FRAME_CYC == 0) && !srst;
      if (cycles == 95000) begin
         mismatches++;
         conclude();
      end
   end

   initial begin
      repeat (19) @(posedge clk);
      #1;
      check({23'h000000, in_ready}, 24'h000000, "ready in reset");
      check({23'h000000, mute_ind}, 24'h000000, "mute in reset");
      @(posedge clk);
      #1 srst = 1'b0;
      @(posedge clk);
      #1;
      check({23'h000000, in_ready}, 24'h000001, "ready after reset");
      chip_rst_n = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check({23'h000000, in_ready}, 24'h000000, "ready in chip reset");
      chip_rst_n = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check({23'h000000, in_ready}, 24'h000001, "ready after chip reset");
      $display("test reset done");
      // buffer still filling, so the pointers overlap
      frames(4);
      check({23'h000000, mute_ind}, 24'h000001, "mute while filling");
      frames(40);
      $display("test fill done");
      // every framing mode; settling pin flips on the fly between them
      for (int m = 0; m < 8; m++) begin
         {pol, trig, dly} = 3'(m);
         slow_sel = m[0];
         frames(3);
         check(rx_l, DC_L, "left word");
         check(rx_r, DC_R, "right word");
      end
      $display("test framing done");
      // mute raised mid-frame gives whole zero words, release restores data
      mute_req = 1'b1;
      frames(3);
      check(rx_l, 24'h000000, "muted left");
      check(rx_r, 24'h000000, "muted right");
      mute_req = 1'b0;
      frames(3);
      check(rx_l, DC_L, "unmuted left");
      check(rx_r, DC_R, "unmuted right");
      $display("test mute done");
      // long latency needs more samples than are held, so the pointers cross
      short_sel = 1'b0;
      frames(1);
      check({23'h000000, mute_ind}, 24'h000001, "mute on long latency");
      $display("test latency done");
      conclude();
   end
endmodule
